// >>> design/ftc_defs.vh
// Register offsets, field positions and reset values of the timer channel
`ifndef FTC_DEFS_VH
`define FTC_DEFS_VH
// APB byte addresses
`define FTC_OFF_CTRL    12'h000
`define FTC_OFF_CNTIN   12'h004
`define FTC_OFF_MOD     12'h008
`define FTC_OFF_CVAL    12'h00C
`define FTC_OFF_CNT     12'h010
`define FTC_OFF_STATUS  12'h014
`define FTC_OFF_MASK    12'h018
// Control register fields
`define FTC_BIT_ELS_A   0
`define FTC_BIT_ELS_B   1
`define FTC_BIT_MS_A    2
`define FTC_BIT_MS_B    3
`define FTC_BIT_CENTER_ALIGNED_SELECT   4
`define FTC_BIT_COMB    5
`define FTC_BIT_DECAP   6
`define FTC_BIT_RUN     7
`define FTC_CTRL_W      8
// Status and mask layout
`define FTC_BIT_CHF     0
`define FTC_BIT_TOF     1
`define FTC_STAT_W      2
// Reset values
`define FTC_CTRL_RST    8'h00
`define FTC_MOD_RST     16'hFFFF
`define FTC_CVAL_RST    16'h0000
`define FTC_CNTIN_RST   16'h0000
`define FTC_STAT_RST    2'h0
`define FTC_MASK_RST    2'h0
`endif

// >>> design/ftc_channel.v
// One timer channel: shared up-counter, flag-only compare and edge PWM
//
// The implementer's own choices: the APB slave port and the address map.
`include "ftc_defs.vh"

module ftc_channel (
  input  wire        i_clock,
  input  wire        i_nrst,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  output reg         o_chan_out,
  output reg         o_chan_out_en,
  output reg         o_irq
);

  // Register state and next values
  reg [`FTC_CTRL_W-1:0] ctrl_reg;
  reg [`FTC_CTRL_W-1:0] ctrl_next;
  reg [15:0]            cntin_reg;
  reg [15:0]            cntin_next;
  reg [15:0]            mod_reg;
  reg [15:0]            mod_next;
  reg [15:0]            cval_reg;
  reg [15:0]            cval_next;
  reg [15:0]            cnt_reg;
  reg [15:0]            cnt_next;
  reg [`FTC_STAT_W-1:0] status_reg;
  reg [`FTC_STAT_W-1:0] mask_reg;
  reg [`FTC_STAT_W-1:0] mask_next;
  reg                   out_next;
  reg                   out_en_next;
  reg                   irq_next;
  reg [31:0]            rdata_next;
  reg                   ready_next;
  reg                   err_next;

  // Control fields
  wire run     = ctrl_reg[`FTC_BIT_RUN];
  wire els_a   = ctrl_reg[`FTC_BIT_ELS_A];
  wire els_b   = ctrl_reg[`FTC_BIT_ELS_B];
  wire base_ok = ~ctrl_reg[`FTC_BIT_DECAP] & ~ctrl_reg[`FTC_BIT_COMB] &
                 ~ctrl_reg[`FTC_BIT_CENTER_ALIGNED_SELECT];
  wire mode_oc   = base_ok & ~ctrl_reg[`FTC_BIT_MS_B] &
                   ctrl_reg[`FTC_BIT_MS_A];
  wire mode_edge_aligned_pulse_mode = base_ok & ctrl_reg[`FTC_BIT_MS_B];
  wire pin_ctl   = mode_edge_aligned_pulse_mode & (els_a | els_b);

  // The access phase is answered in its first cycle: no wait states
  wire acc       = i_psel & i_penable;
  wire setup     = i_psel & ~i_penable;
  wire wr        = acc & i_pwrite & o_pready;
  wire wr_ctrl   = wr & (i_paddr == `FTC_OFF_CTRL);
  wire wr_cntin  = wr & (i_paddr == `FTC_OFF_CNTIN);
  wire wr_mod    = wr & (i_paddr == `FTC_OFF_MOD);
  wire wr_cval   = wr & (i_paddr == `FTC_OFF_CVAL);
  wire wr_cnt    = wr & (i_paddr == `FTC_OFF_CNT);
  wire wr_status = wr & (i_paddr == `FTC_OFF_STATUS);
  wire wr_mask   = wr & (i_paddr == `FTC_OFF_MASK);

  // Counter compares
  wire [15:0] cnt_step = cnt_reg + 16'h0001;
  wire at_mod   = (cnt_reg == mod_reg);
  wire overflow = run & at_mod;
  wire match    = run & (cnt_reg == cval_reg);
  // The pin is a flop, so it follows the count about to be loaded
  wire hit_next = run & ~at_mod & (cnt_step == cval_reg);
  wire val_zero = (cval_reg == 16'h0000);
  wire val_over = (cval_reg > mod_reg);
  // Flag on match in either mode, suppressed at the PWM extremes
  wire edge_aligned_pulse_mode_flag = mode_edge_aligned_pulse_mode & ~val_zero & ~val_over;
  wire chf_set   = match & (mode_oc | edge_aligned_pulse_mode_flag);

  // Status events and clears
  wire [`FTC_STAT_W-1:0] stat_set;
  wire [`FTC_STAT_W-1:0] stat_clr;
  wire [`FTC_STAT_W-1:0] status_next;
  assign stat_set[`FTC_BIT_CHF] = chf_set;
  assign stat_set[`FTC_BIT_TOF] = overflow;
  assign stat_clr = wr_status ? i_pwdata[`FTC_STAT_W-1:0] :
                                {`FTC_STAT_W{1'b0}};

  genvar gi;
  generate
    for (gi = 0; gi < `FTC_STAT_W; gi = gi + 1) begin : g_status
      // Set after clear so a same-cycle event survives
      assign status_next[gi] = stat_set[gi] |
                               (status_reg[gi] & ~stat_clr[gi]);
    end
  endgenerate

  // Register writes
  always @* begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl)
      ctrl_next = i_pwdata[`FTC_CTRL_W-1:0];
  end

  always @* begin
    cntin_next = cntin_reg;
    if (wr_cntin)
      cntin_next = i_pwdata[15:0];
  end

  always @* begin
    mod_next = mod_reg;
    if (wr_mod)
      mod_next = i_pwdata[15:0];
  end

  always @* begin
    cval_next = cval_reg;
    if (wr_cval)
      cval_next = i_pwdata[15:0];
  end

  always @* begin
    mask_next = mask_reg;
    if (wr_mask)
      mask_next = i_pwdata[`FTC_STAT_W-1:0];
  end

  always @* begin
    // One counter feeds the channel so all edges share one period
    cnt_next = cnt_reg;
    if (run) begin
      if (at_mod)
        cnt_next = cntin_reg;
      else
        cnt_next = cnt_step;
    end
    // Writing the count reloads the initial value
    if (wr_cnt)
      cnt_next = cntin_reg;
  end

  always @* begin
    out_next = o_chan_out;
    if (pin_ctl) begin
      // Extremes are steady levels; match and overflow never toggle them
      if (val_zero)
        out_next = els_a;
      else if (val_over)
        out_next = ~els_a;
      else if (overflow)
        out_next = ~els_a;
      else if (hit_next)
        out_next = els_a;
    end
  end

  always @* begin
    out_en_next = pin_ctl;
    irq_next    = |(status_next & mask_next);
  end

  // Read mux, prepared in the setup cycle
  always @* begin
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    ready_next = setup;
    if (setup) begin
      case (i_paddr)
        `FTC_OFF_CTRL:   rdata_next[`FTC_CTRL_W-1:0] = ctrl_reg;
        `FTC_OFF_CNTIN:  rdata_next[15:0] = cntin_reg;
        `FTC_OFF_MOD:    rdata_next[15:0] = mod_reg;
        `FTC_OFF_CVAL:   rdata_next[15:0] = cval_reg;
        `FTC_OFF_CNT:    rdata_next[15:0] = cnt_reg;
        `FTC_OFF_STATUS: rdata_next[`FTC_STAT_W-1:0] = status_reg;
        `FTC_OFF_MASK:   rdata_next[`FTC_STAT_W-1:0] = mask_reg;
        default:         err_next = 1'b1;
      endcase
    end
    // Writes return zero so the data bus is quiet outside reads
    if (i_pwrite)
      rdata_next = 32'h0000_0000;
  end

  // State flops
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_reg <= `FTC_CTRL_RST;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cntin_reg <= `FTC_CNTIN_RST;
    end else begin
      cntin_reg <= cntin_next;
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      mod_reg <= `FTC_MOD_RST;
    end else begin
      mod_reg <= mod_next;
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cval_reg <= `FTC_CVAL_RST;
    end else begin
      cval_reg <= cval_next;
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      mask_reg <= `FTC_MASK_RST;
    end else begin
      mask_reg <= mask_next;
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_reg <= `FTC_CNTIN_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      status_reg <= `FTC_STAT_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  // Outputs leave flops so the pin never glitches on compare ripple
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_chan_out <= 1'b0;
    end else begin
      o_chan_out <= out_next;
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_chan_out_en <= 1'b0;
    end else begin
      o_chan_out_en <= out_en_next;
    end
  end

  // Uses the next mask so a mask write drops the line at once
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= irq_next;
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prdata <= 32'h0000_0000;
    end else begin
      o_prdata <= rdata_next;
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= ready_next;
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pslverr <= 1'b0;
    end else begin
      o_pslverr <= err_next;
    end
  end

endmodule // ftc_channel

// >>> verif/ftc_load.sv
// Pulled-down load on the channel pin, counting high cycles
module ftc_load (
  input  wire       i_clock,
  input  wire       i_clr,
  input  wire       i_pin,
  input  wire       i_pin_en,
  output reg  [7:0] o_high_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // A released pin falls to the pull-down, never the last level
  wire lvl = i_pin_en & i_pin;
  always @(posedge i_clock)
    o_high_cnt <= i_clr ? 8'h00 : o_high_cnt + {7'h00, lvl};
endmodule // ftc_load

// >>> verif/ftc_channel_checker.sv
// Handshake, read data, pin enable and interrupt checks
module ftc_channel_checker (
  input wire        i_clock, i_nrst, i_psel, i_penable, i_pwrite,
  input wire [31:0] o_prdata,
  input wire        o_pready, o_pslverr, o_chan_out_en, o_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  wire wr = i_psel & i_penable & i_pwrite;
  chk_ready_one: assert property (o_pready |=> !o_pready)
    else $error("pready long");
  chk_ready_setup: assert property (i_psel && !i_penable |=> o_pready)
    else $error("pready late");
  chk_idle_quiet: assert property (!i_psel |=> !o_pready)
    else $error("pready unasked");
  chk_ready_gap: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready outside access");
  chk_data_idle: assert property (!o_pready |-> o_prdata == 0)
    else $error("prdata not zero");
  chk_err_zero: assert property (o_pslverr |-> o_pready && !o_prdata)
    else $error("pslverr wrong");
  chk_irq_fall: assert property ($fell(o_irq) |-> $past(wr))
    else $error("irq fell alone");
  chk_en_write: assert property ($changed(o_chan_out_en) |-> $past(wr, 2))
    else $error("enable moved alone");
endmodule // ftc_channel_checker
bind ftc_channel ftc_channel_checker i_ftc_channel_checker (.*);

// >>> verif/timer_channel_compare_edge_aligned_pulse_mode_test.sv
// Register-level test of one timer channel in compare and PWM modes
`include "ftc_defs.vh"
module timer_channel_compare_edge_aligned_pulse_mode_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clock = 0, i_nrst = 0, clr = 0, psel = 0, pen = 0, pwr = 0;
  logic [11:0] addr = 0;
  logic [31:0] wdata = 0, rdata;
  logic        rerr;
  wire  [31:0] prdata;
  wire         prdy, perr, pin, pin_en, irq;
  wire  [7:0]  hc;
  int          n_fail = 0, tests_run = 0;
  // Mode, value, high cycles over two periods, flag expected
  logic [7:0]  tc [6] = '{8'h8A, 8'h8B, 8'h8A, 8'h8A, 8'h84, 8'h88};
  logic [15:0] tv [6] = '{16'h2, 16'h1, 16'h0, 16'h5, 16'h2, 16'h2};
  logic [7:0]  th [6] = '{8'h4, 8'h6, 8'h0, 8'h8, 8'h0, 8'h0};
  logic [5:0]  tf = 6'h33;
  initial forever #25 i_clock = ~i_clock;
  ftc_channel i_ftc_channel (.i_clock(i_clock), .i_nrst(i_nrst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata),
    .o_prdata(prdata), .o_pready(prdy), .o_pslverr(perr), .o_chan_out(pin),
    .o_chan_out_en(pin_en), .o_irq(irq));
  ftc_load i_ftc_load (.i_clock(i_clock), .i_clr(clr), .i_pin(pin),
    .i_pin_en(pin_en), .o_high_cnt(hc));
  task finish_test;
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Idle edge after each transfer keeps psel from toggling in one step
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdata <= d;
    @(posedge i_clock) pen <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      @(posedge i_clock);
      if (prdy === 1'b1) break;
    end
    if (prdy !== 1'b1) begin
      n_fail++;
      finish_test;
    end
    rdata = prdata;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge i_clock);
  endtask
  initial begin
    repeat (3) @(posedge i_clock);
    i_nrst <= 1'b1;
    xfer(0, `FTC_OFF_MOD, 0);
    chk(rdata, 32'h0000FFFF);
    chk(rerr, 0);
    xfer(0, 12'h01C, 0);
    chk(rdata, 32'h0);
    chk(rerr, 1);
    xfer(1, `FTC_OFF_CNTIN, 0);
    xfer(1, `FTC_OFF_MOD, 3);
    xfer(1, `FTC_OFF_MASK, 1);
    for (int i = 0; i < 6; i++) begin
      xfer(1, `FTC_OFF_CTRL, 0);
      xfer(1, `FTC_OFF_STATUS, 3);
      xfer(1, `FTC_OFF_CVAL, tv[i]);
      xfer(1, `FTC_OFF_CNT, 0);
      xfer(1, `FTC_OFF_CTRL, tc[i]);
      repeat (8) @(posedge i_clock);
      clr <= 1'b1;
      @(posedge i_clock) clr <= 1'b0;
      repeat (9) @(posedge i_clock);
      chk(hc, th[i]);
      chk(irq, tf[i]);
      xfer(0, `FTC_OFF_STATUS, 0);
      chk(rdata[0], tf[i]);
    end
    xfer(1, `FTC_OFF_MASK, 0);
    chk(irq, 0);
    finish_test;
  end
endmodule // timer_channel_compare_edge_aligned_pulse_mode_test
